// >>> rtl/csp_pkg.sv
// Constants and types shared by the codec serial configuration port
package csp_pkg;

	// ****************************************************************
	// Word and counter widths
	// ****************************************************************
	localparam int WORD_W     = 16;
	localparam int POS_W      = 10;
	localparam int FIFO_DEPTH = 16;

	// ****************************************************************
	// Frame timing in bit clock periods
	// ****************************************************************
	localparam logic [9:0] FRAME_LEN_SHORT = 10'h100;
	localparam logic [9:0] FRAME_LEN_LONG  = 10'h200;
	localparam logic [9:0] SEC_START_SHORT = 10'h080;
	localparam logic [9:0] SEC_START_LONG  = 10'h100;
	localparam logic [9:0] PRIM_FIRST      = 10'h001;
	localparam logic [9:0] PRIM_LAST       = 10'h010;
	localparam logic [9:0] CONT_WORD_LAST  = 10'h00F;
	localparam logic [3:0] CASCADE_SHORT_MAX = 4'h4;
	localparam logic [3:0] READBACK_BIT    = 4'h9;

	// ****************************************************************
	// Control registers
	// ****************************************************************
	localparam logic [2:0] REG_NOOP  = 3'h0;
	localparam logic [2:0] REG_CTRL1 = 3'h1;
	localparam logic [2:0] REG_CTRL3 = 3'h3;
	localparam logic [2:0] REG_LAST  = 3'h4;
	localparam int         DAC16_BIT = 0;
	localparam int         CONT_BIT  = 5;
	localparam logic [7:0] CTRL_RST  = 8'h00;
	localparam logic [1:0] ROLE_STANDALONE = 2'h0;

	// ****************************************************************
	// Field positions: secondary word and direct configuration word
	// ****************************************************************
	localparam int SEC_DEV_LSB = 13;
	localparam int SEC_RW_BIT  = 12;
	localparam int SEC_REG_LSB = 9;
	localparam int DCF_DEV_LSB = 12;
	localparam int DCF_REG_LSB = 9;
	localparam logic [3:0] DCF_LAST_BIT = 4'hE;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [1:0] {
		CSP_SLOT_NONE = 2'b00,
		CSP_SLOT_PRIM = 2'b01,
		CSP_SLOT_SEC  = 2'b10
	} csp_slot_t;

	typedef enum logic [1:0] {
		CSP_DC_IDLE = 2'b00,
		CSP_DC_DATA = 2'b01,
		CSP_DC_STOP = 2'b10
	} csp_dc_state_t;

endpackage

// >>> rtl/csp_fifo_if.sv
// Valid/ready interface between the port logic and its sample FIFO
`timescale 1ns/10ps
interface csp_fifo_if #(parameter int W = 16);
	logic         wr_valid;
	logic         wr_ready;
	logic [W-1:0] wr_data;
	logic         rd_valid;
	logic         rd_ready;
	logic [W-1:0] rd_data;

	modport fifo_mp (
		input  wr_valid, wr_data, rd_ready,
		output wr_ready, rd_valid, rd_data
	);
	modport user_mp (
		output wr_valid, wr_data, rd_ready,
		input  wr_ready, rd_valid, rd_data
	);
endinterface

// >>> rtl/csp_fifo.sv
// Synchronous FIFO holding converter words ahead of the serial shifter
`timescale 1ns/10ps
module csp_fifo #(
	parameter int W     = 16,
	parameter int DEPTH = 16
) (
	input  wire logic   i_sys_clk,
	input  wire logic   i_rst,
	csp_fifo_if.fifo_mp f
);
	import csp_pkg::*;

	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem [DEPTH];
	logic [AW:0]  wr_ptr_ff;
	logic [AW:0]  rd_ptr_ff;
	wire          empty = (wr_ptr_ff == rd_ptr_ff);
	wire          full  = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) &&
	                      (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
	wire          push  = f.wr_valid && !full;
	wire          pop   = f.rd_ready && !empty;

	assign f.wr_ready = !full;
	assign f.rd_valid = !empty;
	assign f.rd_data  = mem[rd_ptr_ff[AW-1:0]];

	always_ff @(posedge i_sys_clk) begin
		if (push) begin
			mem[wr_ptr_ff[AW-1:0]] <= f.wr_data;
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
		end else begin
			if (push) begin
				wr_ptr_ff <= wr_ptr_ff + 1'b1;
			end
			if (pop) begin
				rd_ptr_ff <= rd_ptr_ff + 1'b1;
			end
		end
	end
endmodule

// >>> rtl/csp_top.sv
// Codec serial port: frame timing, secondary requests, direct configuration
`timescale 1ns/10ps
module csp_top #(
	parameter int FIFO_DEPTH_P = csp_pkg::FIFO_DEPTH
) (
	input  wire logic                       i_sys_clk,
	input  wire logic                       i_rst,
	input  wire logic                       i_bit_clk,
	input  wire logic                       i_serial_data_in,
	input  wire logic                       i_direct_config_serial_in,
	input  wire logic                       i_secondary_request_pin,
	input  wire logic [1:0]                 i_cascade_role_select,
	input  wire logic [3:0]                 i_cascade_count,
	input  wire logic [2:0]                 i_device_addr,
	input  wire logic [csp_pkg::WORD_W-1:0] i_adc_word,
	input  wire logic                       i_adc_valid,
	output logic                            o_adc_ready,
	output logic                            o_frame_sync_strobe,
	output logic                            o_serial_data_out,
	output logic [csp_pkg::WORD_W-1:0]      o_dac_word,
	output logic                            o_dac_valid,
	output logic                            o_sec_pending,
	output logic                            o_dac16_mode,
	output logic                            o_continuous_mode,
	output logic [31:0]                     o_ctrl_regs
);
	import csp_pkg::*;

	// ****************************************************************
	// Input synchronisers and bit clock edges
	// ****************************************************************
	logic [3:0] sync1_ff;
	logic [3:0] sync2_ff;
	logic       sclk_d_ff;
	logic       req_d_ff;
	wire  [3:0] pins_async = {i_bit_clk, i_serial_data_in,
	                          i_direct_config_serial_in, i_secondary_request_pin};
	wire        sclk_s  = sync2_ff[3];
	wire        din_s   = sync2_ff[2];
	wire        direct_config_serial_in_s  = sync2_ff[1];
	wire        req_s   = sync2_ff[0];
	wire        rise_ev = sclk_s && !sclk_d_ff;
	wire        fall_ev = !sclk_s && sclk_d_ff;
	wire        req_pulse = req_s && !req_d_ff;

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			sync1_ff  <= 4'hE;
			sync2_ff  <= 4'hE;
			sclk_d_ff <= 1'b1;
			req_d_ff  <= 1'b0;
		end else begin
			sync1_ff  <= pins_async;
			sync2_ff  <= sync1_ff;
			sclk_d_ff <= sclk_s;
			req_d_ff  <= req_s;
		end
	end

	// ****************************************************************
	// Control registers and mode decode
	// ****************************************************************
	logic [7:0] ctrl_ff [1:4];
	wire        dac16 = ctrl_ff[REG_CTRL1][DAC16_BIT];
	wire        cont  = (i_cascade_role_select == ROLE_STANDALONE) &&
	                    ctrl_ff[REG_CTRL3][CONT_BIT];

	assign o_dac16_mode      = dac16;
	assign o_continuous_mode = cont;
	assign o_ctrl_regs       = {ctrl_ff[4], ctrl_ff[3], ctrl_ff[2], ctrl_ff[1]};

	// ****************************************************************
	// Frame position and slot decode
	// ****************************************************************
	logic [POS_W-1:0] pos_ff;
	logic             sec_run_ff;
	logic             req_ff;
	csp_slot_t        slot_ff;
	logic [3:0]       bit_ff;
	logic [WORD_W-1:0] tx_ff;

	wire              long_frame = (i_cascade_count > CASCADE_SHORT_MAX);
	wire [POS_W-1:0]  frame_last = long_frame ? (FRAME_LEN_LONG - 10'h001)
	                                          : (FRAME_LEN_SHORT - 10'h001);
	wire [POS_W-1:0]  sec_start  = long_frame ? SEC_START_LONG
	                                          : SEC_START_SHORT;
	wire              pos_wrap   = cont ? (pos_ff >= CONT_WORD_LAST)
	                                    : (pos_ff >= frame_last);
	wire [POS_W-1:0]  nxt_pos    = pos_wrap ? '0 : pos_ff + 10'h001;
	wire [POS_W-1:0]  sec_off    = nxt_pos - sec_start;
	wire              prim_fs    = !cont && (nxt_pos == '0);
	wire              cont_fs    = cont && (nxt_pos == CONT_WORD_LAST);
	wire              sec_fs     = !cont && req_ff && (nxt_pos == sec_start);
	wire              in_prim    = !cont && (nxt_pos >= PRIM_FIRST) &&
	                               (nxt_pos <= PRIM_LAST);
	wire              in_sec     = sec_run_ff && (sec_off >= PRIM_FIRST) &&
	                               (sec_off <= PRIM_LAST);
	wire [POS_W-1:0]  prim_idx   = PRIM_LAST - nxt_pos;
	wire [POS_W-1:0]  sec_idx    = PRIM_LAST - sec_off;
	wire [POS_W-1:0]  cont_idx   = CONT_WORD_LAST - nxt_pos;
	csp_slot_t        nxt_slot;
	logic [3:0]       nxt_bit;

	always_comb begin
		nxt_slot = CSP_SLOT_NONE;
		nxt_bit  = 4'h0;
		if (cont) begin
			nxt_slot = CSP_SLOT_PRIM;
			nxt_bit  = cont_idx[3:0];
		end else if (in_prim) begin
			nxt_slot = CSP_SLOT_PRIM;
			nxt_bit  = prim_idx[3:0];
		end else if (in_sec) begin
			nxt_slot = CSP_SLOT_SEC;
			nxt_bit  = sec_idx[3:0];
		end
	end

	// ****************************************************************
	// Transmit word selection and sample FIFO
	// ****************************************************************
	csp_fifo_if #(.W(WORD_W)) adc_q ();

	wire              load_prim = rise_ev && (nxt_slot == CSP_SLOT_PRIM) &&
	                              (nxt_bit == 4'hF);
	wire [WORD_W-1:0] prim_word = adc_q.rd_valid ? adc_q.rd_data : '0;
	wire [WORD_W-1:0] sec_word  = {i_device_addr, 13'h0000};
	wire [WORD_W-1:0] tx_sel    = load_prim ? prim_word : tx_ff;

	assign adc_q.wr_valid = i_adc_valid;
	assign adc_q.wr_data  = i_adc_word;
	assign adc_q.rd_ready = load_prim;
	assign o_adc_ready    = adc_q.wr_ready;

	csp_fifo #(
		.W     (WORD_W),
		.DEPTH (FIFO_DEPTH_P)
	) u_adc_fifo (
		.i_sys_clk (i_sys_clk),
		.i_rst     (i_rst),
		.f         (adc_q)
	);

	// ****************************************************************
	// Receive shifter and word completion
	// ****************************************************************
	logic [WORD_W-1:0] rx_ff;
	wire  [WORD_W-1:0] rx_nxt    = {rx_ff[WORD_W-2:0], din_s};
	wire               in_slot   = fall_ev && (slot_ff != CSP_SLOT_NONE);
	wire               word_done = in_slot && (bit_ff == 4'h0);
	wire               prim_done = word_done && (slot_ff == CSP_SLOT_PRIM);
	wire               sec_done  = word_done && (slot_ff == CSP_SLOT_SEC);
	wire               sw_req    = prim_done && !dac16 && !cont && din_s;
	wire [WORD_W-1:0]  dac_word  = dac16 ? rx_nxt : {rx_nxt[WORD_W-1:1], 1'b0};
	wire               rb_point  = in_slot && (slot_ff == CSP_SLOT_SEC) &&
	                               (bit_ff == READBACK_BIT);
	wire [2:0]         rb_dev    = rx_nxt[6:4];
	wire               rb_read   = rx_nxt[3];
	wire [2:0]         rb_reg    = rx_nxt[2:0];
	wire               rb_ok     = (rb_dev == i_device_addr) && rb_read &&
	                               (rb_reg != REG_NOOP) && (rb_reg <= REG_LAST);
	wire [2:0]         sec_dev   = rx_nxt[SEC_DEV_LSB+2:SEC_DEV_LSB];
	wire [2:0]         sec_reg   = rx_nxt[SEC_REG_LSB+2:SEC_REG_LSB];
	wire               sec_wr    = sec_done && (sec_dev == i_device_addr) &&
	                               !rx_nxt[SEC_RW_BIT] && (sec_reg != REG_NOOP) &&
	                               (sec_reg <= REG_LAST);

	// ****************************************************************
	// Direct configuration receiver
	// ****************************************************************
	csp_dc_state_t dc_state_ff;
	csp_dc_state_t nxt_dc_state;
	logic [3:0]    dc_cnt_ff;
	logic [13:0]   dc_sh_ff;
	wire  [14:0]   dc_word = {dc_sh_ff, direct_config_serial_in_s};
	wire           dc_last = (dc_state_ff == CSP_DC_DATA) && (dc_cnt_ff == DCF_LAST_BIT);
	wire  [2:0]    dc_dev  = dc_word[DCF_DEV_LSB+2:DCF_DEV_LSB];
	wire  [2:0]    dc_reg  = dc_word[DCF_REG_LSB+2:DCF_REG_LSB];
	wire           dc_wr   = fall_ev && dc_last && (dc_dev == i_device_addr) &&
	                         (dc_reg != REG_NOOP) && (dc_reg <= REG_LAST);

	always_comb begin
		nxt_dc_state = dc_state_ff;
		case (dc_state_ff)
			CSP_DC_IDLE: begin
				if (!direct_config_serial_in_s) begin
					nxt_dc_state = CSP_DC_DATA;
				end
			end
			CSP_DC_DATA: begin
				if (dc_last) begin
					nxt_dc_state = CSP_DC_STOP;
				end
			end
			CSP_DC_STOP: begin
				if (direct_config_serial_in_s) begin
					nxt_dc_state = CSP_DC_IDLE;
				end
			end
			default: begin
				nxt_dc_state = CSP_DC_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			dc_state_ff <= CSP_DC_IDLE;
			dc_cnt_ff   <= 4'h0;
			dc_sh_ff    <= 14'h0000;
		end else if (fall_ev) begin
			dc_state_ff <= nxt_dc_state;
			dc_cnt_ff   <= (dc_state_ff == CSP_DC_DATA) ? dc_cnt_ff + 4'h1 : 4'h0;
			dc_sh_ff    <= {dc_sh_ff[12:0], direct_config_serial_in_s};
		end
	end

	// ****************************************************************
	// Register writes; direct configuration wins a same-edge clash
	// ****************************************************************
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			for (int i = 1; i <= 4; i++) begin
				ctrl_ff[i] <= CTRL_RST;
			end
		end else begin
			if (sec_wr) begin
				ctrl_ff[sec_reg] <= rx_nxt[7:0];
			end
			if (dc_wr) begin
				ctrl_ff[dc_reg] <= dc_word[7:0];
			end
		end
	end

	// ****************************************************************
	// Secondary request flag; a set beats a same-cycle clear
	// ****************************************************************
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			req_ff <= 1'b0;
		end else if (req_pulse || sw_req) begin
			req_ff <= 1'b1;
		end else if (sec_done) begin
			req_ff <= 1'b0;
		end
	end

	assign o_sec_pending = req_ff;

	// ****************************************************************
	// Bit clock rising edge: frame position, frame sync and data out
	// ****************************************************************
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			pos_ff              <= '0;
			slot_ff             <= CSP_SLOT_NONE;
			bit_ff              <= 4'h0;
			o_frame_sync_strobe <= 1'b0;
			o_serial_data_out   <= 1'b0;
		end else if (rise_ev) begin
			pos_ff              <= nxt_pos;
			slot_ff             <= nxt_slot;
			bit_ff              <= nxt_bit;
			o_frame_sync_strobe <= prim_fs || cont_fs || sec_fs;
			o_serial_data_out   <= (nxt_slot != CSP_SLOT_NONE) && tx_sel[nxt_bit];
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			tx_ff <= '0;
		end else if (load_prim) begin
			tx_ff <= prim_word;
		end else if (rise_ev && sec_fs) begin
			tx_ff <= sec_word;
		end else if (rb_point) begin
			tx_ff[7:0] <= rb_ok ? ctrl_ff[rb_reg] : 8'h00;
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			sec_run_ff <= 1'b0;
		end else if (rise_ev && sec_fs) begin
			sec_run_ff <= 1'b1;
		end else if (sec_done || cont) begin
			sec_run_ff <= 1'b0;
		end
	end

	// ****************************************************************
	// Bit clock falling edge: receive and DAC word output
	// ****************************************************************
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			rx_ff       <= '0;
			o_dac_word  <= '0;
			o_dac_valid <= 1'b0;
		end else begin
			o_dac_valid <= prim_done;
			if (in_slot) begin
				rx_ff <= rx_nxt;
			end
			if (prim_done) begin
				o_dac_word <= dac_word;
			end
		end
	end
endmodule

// >>> tb/csp_chk_sva.sv
// Assertion checker for the codec serial port top
`timescale 1ns/10ps
module csp_chk
	import csp_pkg::*;
(
	input wire logic                       i_sys_clk,
	input wire logic                       i_rst,
	input wire logic                       i_bit_clk,
	input wire logic [1:0]                 i_cascade_role_select,
	input wire logic                       o_frame_sync_strobe,
	input wire logic                       o_serial_data_out,
	input wire logic [csp_pkg::WORD_W-1:0] o_dac_word,
	input wire logic                       o_dac_valid,
	input wire logic                       o_sec_pending,
	input wire logic                       o_dac16_mode,
	input wire logic                       o_continuous_mode,
	input wire logic [31:0]                o_ctrl_regs
);
	// ****
	// Recent bit clock edges, seen after sync delay
	// ****
	logic [7:0] bc_ff;
	logic       rise_near;
	logic       fall_near;
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			bc_ff <= 8'hFF;
		end else begin
			bc_ff <= {bc_ff[6:0], i_bit_clk};
		end
	end
	assign rise_near = |(bc_ff[4:1] & ~bc_ff[5:2]);
	assign fall_near = |(~bc_ff[4:1] & bc_ff[5:2]);
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (i_rst);
	a_fs_on_rise: assert property ($changed(o_frame_sync_strobe) |-> rise_near)
		else $error("frame sync moved away from a bit clock rise");
	a_dout_on_rise: assert property ($changed(o_serial_data_out) |-> rise_near)
		else $error("serial output moved away from a bit clock rise");
	a_fs_one_bit: assert property (
		$rose(o_frame_sync_strobe) |=> o_frame_sync_strobe[*4] ##[1:8] !o_frame_sync_strobe)
		else $error("frame sync not one bit period wide");
	a_dac_on_fall: assert property (o_dac_valid |-> fall_near)
		else $error("received word not taken at a bit clock fall");
	a_cfg_on_fall: assert property ($changed(o_ctrl_regs) |-> fall_near)
		else $error("control registers changed away from a fall");
	a_flag_clear: assert property ($fell(o_sec_pending) |-> fall_near)
		else $error("request flag cleared away from a word end");
	a_cont_decode: assert property (
		o_continuous_mode == (i_cascade_role_select == ROLE_STANDALONE
			&& o_ctrl_regs[16+CONT_BIT]))
		else $error("continuous mode decode wrong");
	a_width_sel: assert property (o_dac16_mode == o_ctrl_regs[DAC16_BIT])
		else $error("word width select differs from control bit");
	a_lsb_masked: assert property (
		o_dac_valid && !o_dac16_mode |-> o_dac_word[0] == 1'b0)
		else $error("request bit leaked into 15-bit data");
endmodule
bind csp_top csp_chk u_chk (
	.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_bit_clk(i_bit_clk),
	.i_cascade_role_select(i_cascade_role_select),
	.o_frame_sync_strobe(o_frame_sync_strobe), .o_serial_data_out(o_serial_data_out),
	.o_dac_word(o_dac_word), .o_dac_valid(o_dac_valid), .o_sec_pending(o_sec_pending),
	.o_dac16_mode(o_dac16_mode), .o_continuous_mode(o_continuous_mode),
	.o_ctrl_regs(o_ctrl_regs)
);

// >>> tb/csp_host.sv
// Behavioural serial host: bit clock, data words and config line
`timescale 1ns/10ps
module csp_host (
	output logic      o_bit_clk,
	output logic      o_din,
	output logic      o_direct_config_serial_in,
	input  wire logic i_fs,
	input  wire logic i_dout
);
	logic [15:0] hq[$];
	logic [15:0] rxq[$];
	logic [15:0] w;
	logic [15:0] r;
	logic        again;
	event        took;
	event        done;
	initial begin
		o_bit_clk = 1'b1;
		o_din = 1'b0;
		o_direct_config_serial_in = 1'b1;
		again = 1'b0;
		#3;
		forever #40 o_bit_clk = ~o_bit_clk;
	end
	// ****
	// One word per frame sync, zero word when nothing queued
	// ****
	always begin
		if (!again) begin
			@(negedge o_bit_clk);
		end
		again = 1'b0;
		if (i_fs) begin
			w = (hq.size() > 0) ? hq.pop_front() : 16'h0000;
			->took;
			for (int i = 15; i >= 0; i--) begin
				@(posedge o_bit_clk);
				o_din = w[i];
				@(negedge o_bit_clk);
				r[i] = i_dout;
			end
			rxq.push_back(r);
			again = i_fs;
			->done;
		end else begin
			o_din = ~o_din;
		end
	end
	task automatic cfg(input logic [15:0] c);
		for (int i = 15; i >= 0; i--) begin
			@(posedge o_bit_clk);
			o_direct_config_serial_in = c[i];
		end
		@(posedge o_bit_clk);
		o_direct_config_serial_in = 1'b1;
		repeat (2) @(posedge o_bit_clk);
	endtask
endmodule

// >>> tb/testbench.sv
// Self-checking bench for the codec serial port
`timescale 1ns/10ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin mismatches++; \
	$display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module testbench;
	import csp_pkg::*;
	logic              clk;
	logic              rst;
	logic              bclk;
	logic              din;
	logic              direct_config_serial_in;
	logic              pin;
	logic [1:0]        role;
	logic [3:0]        casc;
	logic [WORD_W-1:0] adc;
	logic              adc_v;
	logic              ready;
	logic              fs;
	logic              dout;
	logic [WORD_W-1:0] dac;
	logic              dac_v;
	logic              pend;
	logic              m16;
	logic              cont;
	logic [31:0]       regs;
	logic [31:0]       seed;
	logic [WORD_W-1:0] exp_w;
	logic [WORD_W-1:0] q[$];
	logic [WORD_W-1:0] aq[$];
	int                mismatches = 0;
	int                check_count = 0;
	csp_top dut (
		.i_sys_clk(clk), .i_rst(rst), .i_bit_clk(bclk), .i_serial_data_in(din),
		.i_direct_config_serial_in(direct_config_serial_in), .i_secondary_request_pin(pin),
		.i_cascade_role_select(role), .i_cascade_count(casc), .i_device_addr(3'h3),
		.i_adc_word(adc), .i_adc_valid(adc_v), .o_adc_ready(ready),
		.o_frame_sync_strobe(fs), .o_serial_data_out(dout), .o_dac_word(dac),
		.o_dac_valid(dac_v), .o_sec_pending(pend), .o_dac16_mode(m16),
		.o_continuous_mode(cont), .o_ctrl_regs(regs)
	);
	csp_host host (.o_bit_clk(bclk), .o_din(din), .o_direct_config_serial_in(direct_config_serial_in), .i_fs(fs), .i_dout(dout));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	function automatic logic [15:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[15:0];
	endfunction
	task automatic prim(input logic [15:0] w, input logic [15:0] e, input logic p);
		host.hq.push_back(w);
		@(host.took);
		q.push_back(e);
		@(negedge clk);
		pin = p;
		repeat (3) @(negedge clk);
		pin = 1'b0;
		@(host.done);
	endtask
	task automatic to_fs(output int n);
		n = 0;
		do begin
			@(negedge bclk);
			n++;
		end while (!fs);
	endtask
	task automatic gap(output int n);
		to_fs(n);
		to_fs(n);
	endtask
	task automatic summarize();
		$display("checks %0d, mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// ****
	// Received word monitor and watchdog
	// ****
	always @(negedge clk) begin
		if (dac_v === 1'b1 && q.size() > 0) begin
			exp_w = q.pop_front();
			`CHK(dac, exp_w)
		end
	end
	initial begin
		repeat (95000) @(posedge clk);
		mismatches++;
		summarize();
	end
	// ****
	// Main sequence
	// ****
	initial begin
		int n;
		logic [15:0] d;
		seed = 32'h0000_1438;
		rst = 1'b1;
		pin = 1'b0;
		role = 2'h1;
		casc = 4'h1;
		adc = 16'h0000;
		adc_v = 1'b0;
		repeat (4) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		`CHK(regs, 32'h0000_0000)
		`CHK(m16, 1'b0)
		$display("test reset done");
		@(host.done);
		repeat (3) begin
			@(negedge clk);
			adc = rnd();
			adc_v = 1'b1;
			@(negedge clk);
			adc_v = 1'b0;
			d = rnd() & 16'hFFFE;
			prim(d, d, 1'b0);
			`CHK(host.rxq[$], adc)
		end
		$display("test primary done");
		d = rnd();
		prim(d | 16'h0001, d & 16'hFFFE, 1'b0);
		host.hq.push_back({3'h3, 1'b0, 3'h2, 1'b0, 8'hA5});
		to_fs(n);
		`CHK(n, 112)
		`CHK(pend, 1'b1)
		@(host.done);
		`CHK(host.rxq[$], 16'h6000)
		gap(n);
		`CHK(n, 256)
		`CHK(pend, 1'b0)
		`CHK(regs[15:8], 8'hA5)
		$display("test soft request done");
		@(negedge clk);
		casc = 4'h5;
		gap(n);
		`CHK(n, 512)
		d = rnd();
		prim(d | 16'h0001, d & 16'hFFFE, 1'b1);
		host.hq.push_back({3'h3, 1'b0, 3'h4, 1'b0, 8'h5A});
		to_fs(n);
		`CHK(n, 240)
		@(host.done);
		to_fs(n);
		`CHK(n, 240)
		to_fs(n);
		`CHK(n, 512)
		`CHK(regs[31:24], 8'h5A)
		d = rnd() & 16'hFFFE;
		prim(d, d, 1'b1);
		host.hq.push_back({3'h3, 1'b1, 3'h4, 1'b0, 8'h00});
		to_fs(n);
		`CHK(n, 240)
		@(host.done);
		`CHK(host.rxq[$], 16'h605A)
		$display("test pin request done");
		host.cfg({1'b0, 3'h5, 3'h1, 1'b0, 8'h01});
		`CHK(m16, 1'b0)
		host.cfg({1'b0, 3'h3, 3'h1, 1'b0, 8'h01});
		`CHK(regs[7:0], 8'h01)
		d = rnd() | 16'h0001;
		prim(d, d, 1'b0);
		repeat (8) @(negedge clk);
		`CHK(pend, 1'b0)
		$display("test direct config done");
		@(negedge clk);
		casc = 4'h1;
		host.cfg({1'b0, 3'h3, 3'h3, 1'b0, 8'h20});
		`CHK(cont, 1'b0)
		@(host.done);
		@(negedge clk);
		role = 2'h0;
		@(negedge clk);
		`CHK(cont, 1'b1)
		gap(n);
		`CHK(n, 16)
		// Fill only after the word framed by this sync has been loaded
		@(posedge bclk);
		repeat (8) @(negedge clk);
		adc_v = 1'b1;
		repeat (20) begin
			adc = rnd();
			if (ready === 1'b1) begin
				aq.push_back(adc);
			end
			@(negedge clk);
		end
		adc_v = 1'b0;
		`CHK(aq.size(), FIFO_DEPTH)
		repeat (20) to_fs(n);
		`CHK(ready, 1'b1)
		n = 0;
		while (n < host.rxq.size() && host.rxq[n] !== aq[0]) n++;
		foreach (aq[i]) `CHK(host.rxq[n + i], aq[i])
		$display("test continuous done");
		summarize();
	end
endmodule
